// file: core/uid_dev.sv
// Overview of operation
// - Two independent DMA requests, transmit and receive.
// - Transmit request follows transmitter ready flag.
// - Receive request follows full-or-ready status flag.
// - Status bit1 receive request, bit0 transmit.
// - Mask bits: 7 cts, 2 break, 1 fifo, 0 tx.
// - Mode one bit6 picks ready or full.
// - Software disables DMA when using ready interrupts.
// - Cts change and break still interrupt under DMA.
// - Prefer receive request from receiver ready.
// - Break interrupt at start and end, cleared.
// - Init resets receiver, transmitter, then pointer.
// - Then mask, input enable, clock select.
// - Then mode one fields.
// - Then mode two fields.
// - Enable transmitter/receiver last.
// - Status read never pops receive FIFO.
// - Receiver reset clears FIFO, break, receive status and receive request; flow reopens.
//
// UART channel end: receive FIFO, transmit holding, status, mask, requests.
// Serial side is abstracted as input pulses rx_char_stb, tx_done and pin levels brk_in, cts_in.
`timescale 1ns/1ps
`include "uid_defines.svh"
module uid_dev #(
  parameter int DEPTH = `UID_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  uid_if.dev lnk,
  input wire logic rx_char_stb,
  input wire logic [7:0] rx_char,
  input wire logic tx_done,
  input wire logic brk_in,
  input wire logic cts_in,
  output logic [7:0] tx_char,
  output logic tx_start,
  output logic rx_flow_ok
);

  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [1:0] cnt;
    logic tx_full;
    logic [7:0] tx_hold;
    logic tx_start;
    logic [7:0] imr;
    logic mr1_sel;
    logic [2:0] ptr;
    logic dbrk;
    logic cts_state_change;
    logic [7:0] isr;
    logic irq;
    logic txr, rxr;
    logic rts;
    logic [7:0] rb;
  } uid_dev_st_t;
  uid_dev_st_t q, d;
  logic rxsrc;
  logic pop;
  logic push;
  logic brk_chg;
  logic cts_chg;

  // Break and clear-to-send are pins from outside the clock domain
  uid_pin_filter i_brk_filter (
    .clk(clk),
    .rst_n(rst_n),
    .pin(brk_in),
    .change(brk_chg)
  );
  uid_pin_filter i_cts_filter (
    .clk(clk),
    .rst_n(rst_n),
    .pin(cts_in),
    .change(cts_chg)
  );

  always_comb begin
    d = q;
    d.tx_start = 1'b0;
    pop = lnk.rb_rd && (q.cnt != 2'h0);
    push = rx_char_stb && ((q.cnt != 2'(DEPTH)) || pop);
    if (pop) begin
      d.rb = q.mem[0];
      for (int i = 0; i < DEPTH - 1; i++) begin
        d.mem[i] = q.mem[i+1];
      end
    end
    if (push) begin
      d.mem[2'(q.cnt - 2'(pop))] = rx_char;
    end
    d.cnt = q.cnt + 2'(push) - 2'(pop);
    // Transmit holding register; one character in flight
    if (lnk.tb_wr && !q.tx_full) begin
      d.tx_full = 1'b1;
      d.tx_hold = lnk.tb_data;
      d.tx_start = 1'b1;
    end else if (tx_done) begin
      d.tx_full = 1'b0;
    end
    // Break change at both edges; hardware set wins over clear
    if (brk_chg) begin
      d.dbrk = 1'b1;
    end else if (lnk.brk_clr) begin
      d.dbrk = 1'b0;
    end
    if (cts_chg) begin
      d.cts_state_change = 1'b1;
    end else if (lnk.cos_clr) begin
      d.cts_state_change = 1'b0;
    end
    if (lnk.imr_wr) begin
      d.imr = lnk.imr_data;
    end
    if (lnk.mr1_wr) begin
      d.mr1_sel = lnk.mr1_data[`UID_MR1_RXSEL];
    end
    if (lnk.cmd_stb) begin
      case (lnk.cmd)
        `UID_CMD_PTR_RESET: d.ptr = 3'h0;
        // A character arriving in the reset cycle is dropped with the rest
        `UID_CMD_RX_RESET: begin
          d.cnt = 2'h0;
          d.dbrk = 1'b0;
        end
        `UID_CMD_TX_RESET: d.tx_full = 1'b0;
        default: d.ptr = q.ptr;
      endcase
    end
    // Flow permission drops in the very cycle the last slot fills
    d.rts = (d.cnt != 2'(DEPTH));
    // Bit 6 clear: ready (at least one char); set: FIFO full
    rxsrc = d.mr1_sel ? (d.cnt == 2'(DEPTH)) : (d.cnt != 2'h0);
    d.txr = !d.tx_full;
    d.rxr = rxsrc;
    d.isr = 8'h00;
    d.isr[`UID_BIT_TRANSMITTER_READY_FLAG] = d.txr;
    d.isr[`UID_BIT_RXSRC] = d.rxr;
    d.isr[`UID_BIT_DBRK] = d.dbrk;
    d.isr[`UID_BIT_COS] = d.cts_state_change;
    d.irq = |(d.isr & d.imr);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.txr <= 1'b1;
      q.isr <= 8'h01;
      q.rts <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign lnk.tx_dma_req = q.txr;
  assign lnk.rx_dma_req = q.rxr;
  assign lnk.isr = q.isr;
  assign lnk.imr = q.imr;
  assign lnk.irq = q.irq;
  assign lnk.mode_rx_sel = q.mr1_sel;
  assign lnk.rb_data = q.rb;
  assign tx_char = q.tx_hold;
  assign tx_start = q.tx_start;
  assign rx_flow_ok = q.rts;
endmodule

// Three-flop pin filter: a change counts once flops two and three agree,
// so one unsettled sample never makes an event on its own.
module uid_pin_filter (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic change
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic chg;
  } uid_pin_st_t;
  uid_pin_st_t q, d;

  always_comb begin
    d = q;
    d.s1 = pin;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.chg = 1'b0;
    if ((q.s2 == q.s3) && (q.s3 != q.lvl)) begin
      d.lvl = q.s3;
      d.chg = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign change = q.chg;
endmodule

// file: core/uid_defines.svh
// Constants for the UART interrupt and DMA request block.
// Included by the package user files; definitions only.
`ifndef UID_DEFINES_SVH
`define UID_DEFINES_SVH
// Interrupt status / mask bit positions
`define UID_BIT_TRANSMITTER_READY_FLAG 0
`define UID_BIT_RXSRC 1
`define UID_BIT_DBRK 2
`define UID_BIT_COS 7
// Mode register one receive notification select bit
`define UID_MR1_RXSEL 6
// Command field values
`define UID_CMD_NONE 3'h0
`define UID_CMD_PTR_RESET 3'h1
`define UID_CMD_RX_RESET 3'h2
`define UID_CMD_TX_RESET 3'h3
// Controller register offsets
`define UID_REG_STATUS 4'h0
`define UID_REG_MASK 4'h1
`define UID_REG_MODE1 4'h2
`define UID_REG_CMD 4'h3
`define UID_REG_EVENTS 4'h4
`define UID_REG_DMAEN 4'h5
`define UID_REG_TXDATA 4'h6
`define UID_REG_RXDATA 4'h7
// Receive FIFO depth
`define UID_FIFO_DEPTH 3
`endif

// file: core/uid_pkg.sv
// Types used by the controller end of the UART interrupt and DMA request link.
// Assumes uid_defines.svh is on the include path.
package uid_pkg;
  typedef enum logic [2:0] {
    UID_IDLE = 3'b001,
    UID_XFER = 3'b010,
    UID_WAIT = 3'b100
  } uid_dma_state_t;
endpackage

// file: core/uid_if.sv
// Link between the UART channel end and the DMA / interrupt controller end.
// Both ends share clk and rst_n from the testbench.
`timescale 1ns/1ps
interface uid_if;
  logic tx_dma_req;
  logic rx_dma_req;
  logic irq;
  logic [7:0] isr;
  logic [7:0] imr;
  logic mode_rx_sel;
  logic [2:0] cmd;
  logic cmd_stb;
  logic imr_wr;
  logic [7:0] imr_data;
  logic mr1_wr;
  logic [7:0] mr1_data;
  logic tb_wr;
  logic [7:0] tb_data;
  logic rb_rd;
  logic [7:0] rb_data;
  logic brk_clr;
  logic cos_clr;
  modport dev (
    output tx_dma_req, rx_dma_req, irq, isr, imr, mode_rx_sel, rb_data,
    input cmd, cmd_stb, imr_wr, imr_data, mr1_wr, mr1_data, tb_wr, tb_data, rb_rd,
    input brk_clr, cos_clr
  );
  modport ctl (
    input tx_dma_req, rx_dma_req, irq, isr, imr, mode_rx_sel, rb_data,
    output cmd, cmd_stb, imr_wr, imr_data, mr1_wr, mr1_data, tb_wr, tb_data, rb_rd,
    output brk_clr, cos_clr
  );
endinterface

// file: core/uid_ctl.sv
// Controller end: passes the software's init commands and writes on, serves DMA requests and the
// interrupt. Software orders it through a plain register port.
`timescale 1ns/1ps
`include "uid_defines.svh"
module uid_ctl (
  input wire logic clk,
  input wire logic rst_n,
  uid_if.ctl lnk,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic irq_out
);
  typedef struct packed {
    logic [7:0] rdata;
    logic [1:0] dmaen;
    logic [7:0] txd;
    logic tx_pend;
    logic [7:0] rxd;
    logic [1:0] ev;
    logic [1:0] evmask;
    logic irq;
    logic [2:0] cmd;
    logic cmd_stb;
    logic imr_wr, mr1_wr, tb_wr, rb_rd, rd_pend, brk_clr, cos_clr;
    logic [7:0] wd;
    uid_pkg::uid_dma_state_t st;
  } uid_ctl_st_t;
  uid_ctl_st_t q, d;
  logic [1:0] ev_set;
  always_comb begin
    d = q;
    d.cmd_stb = 1'b0;
    d.imr_wr = 1'b0;
    d.mr1_wr = 1'b0;
    d.tb_wr = 1'b0;
    d.rb_rd = 1'b0;
    d.brk_clr = 1'b0;
    d.cos_clr = 1'b0;
    d.rdata = 8'h00;
    // Event 0: device irq level seen; event 1: rx word landed
    ev_set = {q.rd_pend, lnk.irq};
    d.ev = q.ev | ev_set;
    if (q.rd_pend) begin
      d.rxd = lnk.rb_data;
    end
    d.rd_pend = q.rb_rd;
    if (wr) begin
      case (addr)
        `UID_REG_MASK: begin
          d.imr_wr = 1'b1;
          d.wd = wdata;
        end
        `UID_REG_MODE1: begin
          d.mr1_wr = 1'b1;
          d.wd = wdata;
        end
        `UID_REG_CMD: begin
          d.cmd = wdata[2:0];
          d.cmd_stb = 1'b1;
          d.brk_clr = wdata[4];
          d.cos_clr = wdata[5];
        end
        `UID_REG_EVENTS: d.ev = (q.ev & ~wdata[1:0]) | ev_set;
        `UID_REG_DMAEN: d.dmaen = wdata[1:0];
        `UID_REG_TXDATA: begin
          d.txd = wdata;
          d.tx_pend = 1'b1;
        end
        `UID_REG_STATUS: d.evmask = wdata[1:0];
        default: d.wd = q.wd;
      endcase
    end
    if (rd) begin
      case (addr)
        `UID_REG_STATUS: d.rdata = lnk.isr;
        `UID_REG_MASK: d.rdata = lnk.imr;
        `UID_REG_EVENTS: d.rdata = {4'h0, q.evmask, q.ev};
        `UID_REG_DMAEN: d.rdata = {6'h00, q.dmaen};
        `UID_REG_RXDATA: d.rdata = q.rxd;
        default: d.rdata = 8'h00;
      endcase
    end
    // One DMA transfer at a time; wait a cycle for the request to settle
    case (q.st)
      uid_pkg::UID_IDLE: begin
        // The write bus is shared, so a mask or mode write holds the transfer back
        if (q.dmaen[0] && lnk.tx_dma_req && q.tx_pend && !d.imr_wr && !d.mr1_wr) begin
          d.tb_wr = 1'b1;
          d.wd = q.txd;
          d.tx_pend = 1'b0;
          d.st = uid_pkg::UID_XFER;
        end else if (q.dmaen[1] && lnk.rx_dma_req) begin
          d.rb_rd = 1'b1;
          d.st = uid_pkg::UID_XFER;
        end
      end
      uid_pkg::UID_XFER: d.st = uid_pkg::UID_WAIT;
      uid_pkg::UID_WAIT: d.st = uid_pkg::UID_IDLE;
      default: d.st = uid_pkg::UID_IDLE;
    endcase
    d.irq = |(d.ev & d.evmask);
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.st <= uid_pkg::UID_IDLE;
    end else begin
      q <= d;
    end
  end
  assign lnk.cmd = q.cmd;
  assign lnk.cmd_stb = q.cmd_stb;
  assign lnk.imr_wr = q.imr_wr;
  assign lnk.imr_data = q.wd;
  assign lnk.mr1_wr = q.mr1_wr;
  assign lnk.mr1_data = q.wd;
  assign lnk.tb_wr = q.tb_wr;
  assign lnk.tb_data = q.wd;
  assign lnk.rb_rd = q.rb_rd;
  assign lnk.brk_clr = q.brk_clr;
  assign lnk.cos_clr = q.cos_clr;
  assign rdata = q.rdata;
  assign irq_out = q.irq;
endmodule

// file: testbench/uid_checker.sv
// Checker for the request and interrupt link between the two ends.
// Sees the interface signals as plain inputs; one clock, one reset.
`timescale 1ns/1ps
module uid_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tx_dma_req,
  input wire logic rx_dma_req,
  input wire logic irq,
  input wire logic [7:0] isr,
  input wire logic [7:0] imr,
  input wire logic mode_rx_sel,
  input wire logic [2:0] cmd,
  input wire logic cmd_stb,
  input wire logic imr_wr,
  input wire logic [7:0] imr_data,
  input wire logic mr1_wr,
  input wire logic [7:0] mr1_data,
  input wire logic tb_wr,
  input wire logic rb_rd,
  input wire logic brk_clr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_tx_req_flag: assert property (tx_dma_req == isr[0])
    else $error("transmit request differs from status bit 0");
  a_rx_req_flag: assert property (rx_dma_req == isr[1])
    else $error("receive request differs from status bit 1");
  a_tx_req_drop: assert property (tb_wr && tx_dma_req |=> !tx_dma_req)
    else $error("transmit request held after buffer write");
  a_mask_load: assert property (imr_wr |=> (imr & 8'h87) == ($past(imr_data) & 8'h87))
    else $error("mask readback wrong after write");
  a_mode_sel: assert property (mr1_wr |=> mode_rx_sel == $past(mr1_data[6]))
    else $error("receive select not taken from mode bit 6");
  a_rx_reset: assert property (cmd_stb && cmd == 3'h2 |=> !rx_dma_req && !isr[1])
    else $error("receive request survives receiver reset");
  a_rx_hold: assert property (rx_dma_req && !rb_rd && !cmd_stb && !mr1_wr |=> rx_dma_req)
    else $error("receive request dropped without a pop");
  a_brk_sticky: assert property (isr[2] && !brk_clr && !(cmd_stb && cmd == 3'h2) |=> isr[2])
    else $error("break status lost without a clear");
  a_irq_on: assert property ((|(isr & imr & 8'h87)) [*3] |-> irq)
    else $error("interrupt low with an unmasked source");
  a_irq_off: assert property (((isr & imr & 8'h87) == 8'h00) [*3] |-> !irq)
    else $error("interrupt high with no unmasked source");
endmodule

// file: testbench/uart_irq_dma_request_setup_bench.sv
// Bench: software port of the controller, serial side of the channel end.
// Both ends joined by one link; checker sits beside that link.
`timescale 1ns/1ps
module uart_irq_dma_request_setup_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic irq_out;
  logic rx_char_stb = 1'b0;
  logic [7:0] rx_char = 8'h00;
  logic tx_done = 1'b0;
  logic brk_in = 1'b0;
  logic cts_in = 1'b0;
  logic [7:0] tx_char;
  logic tx_start;
  logic rx_flow_ok;
  int error_cnt = 0;
  int check_count = 0;
  int tx_start_cnt = 0;
  always #5 clk = ~clk;
  // Count transmit starts so the one-cycle pulse cannot slip past a check
  always @(posedge clk) begin
    if (tx_start) begin
      tx_start_cnt++;
    end
  end
  uid_if lnk ();
  uid_dev i_uid_dev (.clk(clk), .rst_n(rst_n), .lnk(lnk), .rx_char_stb(rx_char_stb),
    .rx_char(rx_char), .tx_done(tx_done), .brk_in(brk_in), .cts_in(cts_in),
    .tx_char(tx_char), .tx_start(tx_start), .rx_flow_ok(rx_flow_ok));
  uid_ctl i_uid_ctl (.clk(clk), .rst_n(rst_n), .lnk(lnk), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq_out(irq_out));
  uid_checker i_uid_checker (.clk(clk), .rst_n(rst_n), .tx_dma_req(lnk.tx_dma_req),
    .rx_dma_req(lnk.rx_dma_req), .irq(lnk.irq), .isr(lnk.isr), .imr(lnk.imr),
    .mode_rx_sel(lnk.mode_rx_sel), .cmd(lnk.cmd), .cmd_stb(lnk.cmd_stb),
    .imr_wr(lnk.imr_wr), .imr_data(lnk.imr_data), .mr1_wr(lnk.mr1_wr),
    .mr1_data(lnk.mr1_data), .tb_wr(lnk.tb_wr), .rb_rd(lnk.rb_rd), .brk_clr(lnk.brk_clr));
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rd_chk(input string name, input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(name, exp, rdata);
  endtask
  task automatic push(input logic [7:0] c);
    @(posedge clk);
    rx_char <= c;
    rx_char_stb <= 1'b1;
    @(posedge clk);
    rx_char_stb <= 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Whole sequence needs well under 1000 cycles
  initial begin
    #50000;
    error_cnt++;
    summarize();
  end
  initial begin
    idle(8);
    rst_n <= 1'b1;
    rd_chk("status", 4'h0, 8'h01);
    rd_chk("mask", 4'h1, 8'h00);
    wr_reg(4'h3, 8'h02);
    wr_reg(4'h3, 8'h03);
    wr_reg(4'h3, 8'h01);
    wr_reg(4'h1, 8'h87);
    wr_reg(4'h2, 8'h00);
    rd_chk("mask", 4'h1, 8'h87);
    push(8'h5a);
    idle(2);
    rd_chk("status", 4'h0, 8'h03);
    rd_chk("status", 4'h0, 8'h03);
    wr_reg(4'h5, 8'h02);
    idle(4);
    rd_chk("rx data", 4'h7, 8'h5a);
    wr_reg(4'h5, 8'h00);
    idle(2);
    rd_chk("status", 4'h0, 8'h01);
    wr_reg(4'h2, 8'h40);
    push(8'h11);
    push(8'h22);
    idle(2);
    rd_chk("status", 4'h0, 8'h01);
    push(8'h33);
    idle(2);
    rd_chk("status", 4'h0, 8'h03);
    chk("flow", 8'h00, {7'h00, rx_flow_ok});
    wr_reg(4'h3, 8'h02);
    idle(2);
    rd_chk("status", 4'h0, 8'h01);
    chk("flow", 8'h01, {7'h00, rx_flow_ok});
    wr_reg(4'h5, 8'h01);
    wr_reg(4'h6, 8'hc3);
    idle(2);
    rd_chk("status", 4'h0, 8'h00);
    chk("tx char", 8'hc3, tx_char);
    @(posedge clk);
    tx_done <= 1'b1;
    @(posedge clk);
    tx_done <= 1'b0;
    idle(2);
    rd_chk("status", 4'h0, 8'h01);
    wr_reg(4'h6, 8'h3c);
    idle(2);
    rd_chk("status", 4'h0, 8'h00);
    chk("tx char", 8'h3c, tx_char);
    wr_reg(4'h3, 8'h03);
    idle(2);
    rd_chk("status", 4'h0, 8'h01);
    chk("tx starts", 8'h02, 8'(tx_start_cnt));
    wr_reg(4'h1, 8'h84);
    idle(2);
    wr_reg(4'h0, 8'h01);
    wr_reg(4'h4, 8'hff);
    idle(2);
    chk("irq", 8'h00, {7'h00, irq_out});
    brk_in <= 1'b1;
    idle(8);
    rd_chk("status", 4'h0, 8'h05);
    chk("irq", 8'h01, {7'h00, irq_out});
    wr_reg(4'h0, 8'h00);
    idle(2);
    chk("irq", 8'h00, {7'h00, irq_out});
    wr_reg(4'h0, 8'h01);
    wr_reg(4'h3, 8'h10);
    wr_reg(4'h4, 8'hff);
    idle(2);
    rd_chk("status", 4'h0, 8'h01);
    chk("irq", 8'h00, {7'h00, irq_out});
    @(posedge clk);
    brk_in <= 1'b0;
    idle(8);
    rd_chk("status", 4'h0, 8'h05);
    @(posedge clk);
    cts_in <= 1'b1;
    idle(8);
    rd_chk("status", 4'h0, 8'h85);
    wr_reg(4'h3, 8'h30);
    idle(2);
    rd_chk("status", 4'h0, 8'h01);
    wr_reg(4'h2, 8'h00);
    wr_reg(4'h5, 8'h02);
    push(8'h44);
    idle(12);
    rd_chk("status", 4'h0, 8'h01);
    rd_chk("rx data", 4'h7, 8'h44);
    rd_chk("events", 4'h4, 8'h07);
    summarize();
  end
endmodule
